// ---- include/ccr_consts.svh ----
`ifndef CCR_CONSTS_SVH
`define CCR_CONSTS_SVH
// ----------------------------------------
// Register access
// ----------------------------------------
`define CCR_CODE 12'h002
`define CCR_RST 32'h0000_0000
`define CCR_MASK 32'h98f0_07ff
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CCR_B_ON 31
`define CCR_B_PUSH 28
`define CCR_B_FRZ 27
`define CCR_B_INV 24
`define CCR_B_IOFF 23
`define CCR_B_DOFF 22
`define CCR_B_ISEL 21
`define CCR_B_DSEL 20
// ----------------------------------------
// Invalidation timing
// ----------------------------------------
`define CCR_OVH_CYC 4'h2
`define CCR_LAST_IDX 9'h1ff
`define CCR_HALF_LO 9'h0ff
`define CCR_HALF_HI 9'h100
`endif

// ---- include/ccr_pkg.sv ----
`default_nettype none

package ccr_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_OVH,
        ST_CLR
    } ccr_seq_type;

    typedef struct packed {
        logic cache_on;
        logic icache_en;
        logic dcache_en;
        logic split;
        logic freeze;
        logic push_inval_en;
        logic [10:0] def_attr;
    } ccr_cfg_type;

    typedef struct packed {
        logic go;
        logic [8:0] first;
        logic [8:0] last;
    } ccr_range_type;
endpackage

`default_nettype wire

// ---- logic/ccr_cache_ctrl.sv ----
// Functional notes
// - Supervisor write-only word, control code 0x002
// - Debug port reads the stored word back
// - Reset clears the whole control word
// - Word supplies default access attributes
// - Bit 31 enables the cache array
// - Bit 28 clear: line push invalidates entry
// - Freeze: never overwrite a valid entry
// - Freeze: invalid target may still fill
// - Invalidate works whether cache on or off
// - Invalidate scope from disables and selects
// - Clear one tag per cycle after overhead
// - Invalidate bit is never stored, reads zero
// - Bit 23 stops instruction caching
// - Bit 22 stops data caching
// - Select bits count only while bits 23 and 22 are both clear
`include "ccr_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module ccr_cache_ctrl (
    // Clock, reset, enable
    input wire logic I_REF_CLK,
    input wire logic I_NRST,
    input wire logic I_CE,
    // Control register write from the core
    input wire logic I_MOVC_WR,
    input wire logic I_MOVC_SUPV,
    input wire logic [11:0] I_MOVC_CODE,
    input wire logic [31:0] I_MOVC_DATA,
    // Debug read
    input wire logic I_DBG_RD,
    input wire logic [11:0] I_DBG_CODE,
    output logic O_DBG_ACK,
    output logic [31:0] O_DBG_DATA,
    // Line push
    input wire logic I_PUSH_REQ,
    input wire logic [8:0] I_PUSH_ADDR,
    // Fill buffer write-back request
    input wire logic I_FILL_REQ,
    input wire logic I_FILL_TGT_VALID,
    output logic O_FILL_WR_EN,
    // Tag invalidation
    output logic O_TAG_INV_WE,
    output logic [8:0] O_TAG_INV_IDX,
    output logic O_INV_BUSY,
    // Cache configuration
    output ccr_pkg::ccr_cfg_type O_CFG
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic ccr_pkg::ccr_range_type inv_range(
        input logic [31:0] d
    );
        ccr_pkg::ccr_range_type r;
        r.go = 1'b1;
        r.first = 9'h000;
        r.last = `CCR_LAST_IDX;
        if (!d[`CCR_B_IOFF] && !d[`CCR_B_DOFF]) begin
            if (d[`CCR_B_ISEL] && d[`CCR_B_DSEL]) begin
                r.go = 1'b0;
            end else if (d[`CCR_B_ISEL]) begin
                r.first = `CCR_HALF_HI;
            end else if (d[`CCR_B_DSEL]) begin
                r.last = `CCR_HALF_LO;
            end
        end else if (d[`CCR_B_IOFF] && d[`CCR_B_DOFF]) begin
            r.go = 1'b0;
        end
        return r;
    endfunction

    function automatic ccr_pkg::ccr_cfg_type make_cfg(
        input logic [31:0] c
    );
        ccr_pkg::ccr_cfg_type g;
        g.cache_on = c[`CCR_B_ON];
        g.icache_en = c[`CCR_B_ON] && !c[`CCR_B_IOFF];
        g.dcache_en = c[`CCR_B_ON] && !c[`CCR_B_DOFF];
        g.split = g.icache_en && g.dcache_en;
        g.freeze = c[`CCR_B_FRZ];
        g.push_inval_en = !c[`CCR_B_PUSH];
        g.def_attr = c[10:0];
        return g;
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [31:0] ctl_r, ctl_nxt;
    ccr_pkg::ccr_seq_type st_r, st_nxt;
    logic [8:0] idx_r, idx_nxt;
    logic [8:0] last_r, last_nxt;
    logic [3:0] ovh_r, ovh_nxt;
    logic we_r, we_nxt;
    logic [8:0] tidx_r, tidx_nxt;
    logic fill_r, fill_nxt;
    logic [31:0] dbg_r, dbg_nxt;
    logic ack_r, ack_nxt;
    logic busy_r, busy_nxt;
    ccr_pkg::ccr_cfg_type cfg_r, cfg_nxt;
    ccr_pkg::ccr_range_type rng;
    logic wr;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        ctl_nxt = ctl_r;
        st_nxt = st_r;
        idx_nxt = idx_r;
        last_nxt = last_r;
        ovh_nxt = ovh_r;
        we_nxt = 1'b0;
        tidx_nxt = tidx_r;
        fill_nxt = 1'b0;
        dbg_nxt = dbg_r;
        ack_nxt = 1'b0;
        rng = inv_range(I_MOVC_DATA);
        wr = I_MOVC_WR && I_MOVC_SUPV && I_MOVC_CODE == `CCR_CODE;
        if (wr) begin
            ctl_nxt = I_MOVC_DATA & `CCR_MASK;
            if (I_MOVC_DATA[`CCR_B_IOFF] || I_MOVC_DATA[`CCR_B_DOFF]) begin
                ctl_nxt[`CCR_B_ISEL] = 1'b0;
                ctl_nxt[`CCR_B_DSEL] = 1'b0;
            end
        end
        case (st_r)
            ccr_pkg::ST_IDLE: begin
                if (wr && I_MOVC_DATA[`CCR_B_INV] && rng.go) begin
                    st_nxt = ccr_pkg::ST_OVH;
                    ovh_nxt = 4'h0;
                    idx_nxt = rng.first;
                    last_nxt = rng.last;
                end else if (I_PUSH_REQ && !ctl_r[`CCR_B_PUSH]) begin
                    we_nxt = 1'b1;
                    tidx_nxt = I_PUSH_ADDR;
                end
            end
            ccr_pkg::ST_OVH: begin
                if (ovh_r == `CCR_OVH_CYC - 4'h1) begin
                    st_nxt = ccr_pkg::ST_CLR;
                end else begin
                    ovh_nxt = ovh_r + 4'h1;
                end
            end
            ccr_pkg::ST_CLR: begin
                we_nxt = 1'b1;
                tidx_nxt = idx_r;
                idx_nxt = idx_r + 9'h001;
                if (idx_r == last_r) begin
                    st_nxt = ccr_pkg::ST_IDLE;
                end
            end
            default: begin
                st_nxt = ccr_pkg::ST_IDLE;
            end
        endcase
        busy_nxt = st_nxt != ccr_pkg::ST_IDLE;
        fill_nxt = I_FILL_REQ && ctl_r[`CCR_B_ON]
            && (!ctl_r[`CCR_B_FRZ] || !I_FILL_TGT_VALID);
        if (I_DBG_RD) begin
            ack_nxt = 1'b1;
            dbg_nxt = (I_DBG_CODE == `CCR_CODE) ? ctl_r : 32'h0000_0000;
        end
        cfg_nxt = make_cfg(ctl_nxt);
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            ctl_r <= `CCR_RST;
            st_r <= ccr_pkg::ST_IDLE;
            idx_r <= 9'h000;
            last_r <= 9'h000;
            ovh_r <= 4'h0;
            we_r <= 1'b0;
            tidx_r <= 9'h000;
            fill_r <= 1'b0;
            dbg_r <= 32'h0000_0000;
            ack_r <= 1'b0;
            busy_r <= 1'b0;
            cfg_r <= '0;
        end else if (I_CE) begin
            ctl_r <= ctl_nxt;
            st_r <= st_nxt;
            idx_r <= idx_nxt;
            last_r <= last_nxt;
            ovh_r <= ovh_nxt;
            we_r <= we_nxt;
            tidx_r <= tidx_nxt;
            fill_r <= fill_nxt;
            dbg_r <= dbg_nxt;
            ack_r <= ack_nxt;
            busy_r <= busy_nxt;
            cfg_r <= cfg_nxt;
        end
    end

    assign O_DBG_ACK = ack_r;
    assign O_DBG_DATA = dbg_r;
    assign O_FILL_WR_EN = fill_r;
    assign O_TAG_INV_WE = we_r;
    assign O_TAG_INV_IDX = tidx_r;
    assign O_INV_BUSY = busy_r;
    assign O_CFG = cfg_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (!I_NRST);

    a_user_write_ignored: assert property (
        I_CE && I_MOVC_WR && !I_MOVC_SUPV && !I_PUSH_REQ
        && !I_DBG_RD |=> $stable(ctl_r))
        else $error("user mode write changed control word");

    a_dbg_readback: assert property (
        I_CE && I_DBG_RD && I_DBG_CODE == 12'h002
        |=> O_DBG_ACK && O_DBG_DATA == $past(ctl_r))
        else $error("debug read returned wrong word");

    a_cmd_reads_zero: assert property (
        O_DBG_ACK |-> !O_DBG_DATA[24])
        else $error("invalidate bit read as one");

    a_push_inval: assert property (
        I_CE && st_r == ccr_pkg::ST_IDLE && I_PUSH_REQ && !wr
        && !ctl_r[28] |=> O_TAG_INV_WE && O_TAG_INV_IDX == $past(I_PUSH_ADDR))
        else $error("line push did not invalidate");

    a_push_blocked: assert property (
        I_CE && st_r == ccr_pkg::ST_IDLE && ctl_r[28]
        |=> !O_TAG_INV_WE)
        else $error("line push invalidated while disabled");

    a_freeze_valid: assert property (
        I_CE && ctl_r[27] && I_FILL_TGT_VALID |=> !O_FILL_WR_EN)
        else $error("frozen valid entry overwritten");

    a_freeze_invalid: assert property (
        I_CE && ctl_r[31] && I_FILL_REQ && !I_FILL_TGT_VALID
        |=> O_FILL_WR_EN)
        else $error("fill into invalid entry refused");

    a_inv_disabled: assert property (
        I_CE && st_r == ccr_pkg::ST_IDLE && wr && I_MOVC_DATA[24]
        && !I_MOVC_DATA[31] && !I_MOVC_DATA[23] && !I_MOVC_DATA[22]
        && !I_MOVC_DATA[21] && !I_MOVC_DATA[20] |=> O_INV_BUSY)
        else $error("invalidate gated by enable");

    a_half_first: assert property (
        I_CE && st_r == ccr_pkg::ST_IDLE && wr && I_MOVC_DATA[24]
        && I_MOVC_DATA[23:20] == 4'h2 |=> idx_r == 9'h100
        && last_r == 9'h1ff)
        else $error("instruction half range wrong");

    a_clear_step: assert property (
        I_CE && st_r == ccr_pkg::ST_CLR && idx_r != last_r
        |=> O_TAG_INV_WE && O_TAG_INV_IDX == $past(idx_r)
        && idx_r == $past(idx_r) + 9'h001)
        else $error("sequencer skipped an entry");

    a_sel_ignored: assert property (
        I_CE && wr && I_MOVC_DATA[23] |=> !ctl_r[21] && !ctl_r[20])
        else $error("select bit kept outside split");

    a_split_cfg: assert property (
        O_CFG.split |-> O_CFG.icache_en && O_CFG.dcache_en
        && ctl_r[31] && !ctl_r[23] && !ctl_r[22])
        else $error("split reported wrongly");

    a_icache_off: assert property (
        O_CFG.icache_en == (ctl_r[31] && !ctl_r[23]))
        else $error("instruction caching state wrong");

    a_dcache_off: assert property (
        O_CFG.dcache_en == (ctl_r[31] && !ctl_r[22]))
        else $error("data caching state wrong");

endmodule

`default_nettype wire

// ---- verification/cache_control_register_logic_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ccr_consts.svh"

module cache_control_register_logic_tb;
    logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, dbg_rd = 1'b0;
    logic push = 1'b0, fill = 1'b0, tv = 1'b0;
    logic wr, supv, ack, fwe, twe, busy;
    logic [11:0] code, dbg_code = 12'h000;
    logic [31:0] wdata, ddata, r, d, mw = 32'h0000_0000;
    logic [31:0] seed = 32'h0000_0025;
    logic [8:0] paddr = 9'h000, tidx;
    logic [8:0] q[$];
    ccr_pkg::ccr_cfg_type cfg;
    int n_fail = 0, samples_checked = 0, busy_cyc = 0;

    always #20 clk = ~clk;

    ccr_core_model i_ccr_core_model (.i_clk(clk), .o_wr(wr), .o_supv(supv),
        .o_code(code), .o_data(wdata));
    ccr_cache_ctrl i_ccr_cache_ctrl (.I_REF_CLK(clk), .I_NRST(nrst),
        .I_CE(ce), .I_MOVC_WR(wr), .I_MOVC_SUPV(supv), .I_MOVC_CODE(code),
        .I_MOVC_DATA(wdata), .I_DBG_RD(dbg_rd), .I_DBG_CODE(dbg_code),
        .O_DBG_ACK(ack), .O_DBG_DATA(ddata), .I_PUSH_REQ(push),
        .I_PUSH_ADDR(paddr), .I_FILL_REQ(fill), .I_FILL_TGT_VALID(tv),
        .O_FILL_WR_EN(fwe), .O_TAG_INV_WE(twe), .O_TAG_INV_IDX(tidx),
        .O_INV_BUSY(busy), .O_CFG(cfg));

    always @(posedge clk) begin
        if (twe === 1'b1) q.push_back(tidx);
        if (busy === 1'b1) busy_cyc++;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask

    task automatic complete_run();
        $display("Counts: %0d checked, %0d failed", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic wr_word(input logic s, input logic [11:0] c,
                           input logic [31:0] v);
        i_ccr_core_model.put(s, c, v);
        if (s && c == `CCR_CODE && ce) begin
            mw = v & 32'h99ff_ffff & `CCR_MASK;
            if (v[23] | v[22]) mw[21:20] = 2'b00;
        end
    endtask

    task automatic dbg_read(input logic [11:0] c, output logic [31:0] v);
        @(posedge clk);
        #1;
        dbg_rd = 1'b1;
        dbg_code = c;
        @(posedge clk);
        #1;
        dbg_rd = 1'b0;
        chk(ack === 1'b1, "no debug answer");
        v = ddata;
    endtask

    task automatic check_word();
        logic [31:0] v;
        dbg_read(`CCR_CODE, v);
        chk(v === mw, "stored word differs");
        chk(cfg.cache_on === mw[31] && cfg.freeze === mw[27], "cfg");
        chk(cfg.push_inval_en === ~mw[28], "push enable");
        chk(cfg.def_attr === mw[10:0], "default attributes");
        chk(cfg.icache_en === (mw[31] & ~mw[23]) &&
            cfg.dcache_en === (mw[31] & ~mw[22]) &&
            cfg.split === (mw[31] & ~mw[23] & ~mw[22]), "mode");
    endtask

    task automatic inval(input logic [31:0] v);
        logic [8:0] f;
        int n;
        logic ok;
        f = 9'h000;
        n = 512;
        if (v[23] & v[22]) n = 0;
        else if (!v[23] && !v[22]) begin
            if (v[21] & v[20]) n = 0;
            else if (v[21]) begin
                f = 9'h100;
                n = 256;
            end else if (v[20]) n = 256;
        end
        q.delete();
        busy_cyc = 0;
        wr_word(1'b1, `CCR_CODE, v | 32'h0100_0000);
        if (n > 0) begin
            // A line push during the sweep must leave no extra entry
            d = rnd();
            paddr = d[8:0];
            push = 1'b1;
            @(posedge clk);
            #1 push = 1'b0;
        end
        for (int k = 0; k < 600 && busy === 1'b1; k++) @(posedge clk);
        repeat (2) @(posedge clk);
        ok = (q.size() == n);
        foreach (q[i]) if (q[i] !== f + i) ok = 1'b0;
        chk(ok, "invalidation scope");
        if (n > 0) chk(busy_cyc == n + 2, "busy span");
        check_word();
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        #(40 * 40000);
        n_fail++;
        $display("ERROR %0t watchdog expired", $time);
        complete_run();
    end

    initial begin
        repeat (20) @(posedge clk);
        #1 nrst = 1'b1;
        repeat (2) @(posedge clk);
        dbg_read(`CCR_CODE, r);
        chk(r === 32'h0000_0000 && busy === 1'b0, "reset word");
        $display("reset test done");
        for (int k = 0; k < 32; k++) inval({k[4], 7'h00, k[3:0], 20'h00000});
        $display("invalidate test done");
        for (int k = 0; k < 40; k++) begin
            d = rnd() & 32'hfeff_ffff;
            ce = |d[9:8];
            wr_word(d[7:6] != 2'b00, d[5:4] == 2'b00 ? 12'h004 : `CCR_CODE, d);
            ce = 1'b1;
            check_word();
        end
        dbg_read(12'h004, r);
        chk(r === 32'h0000_0000, "other code read");
        $display("write test done");
        for (int k = 0; k < 8; k++) begin
            d = rnd() & 32'hfeff_ffff;
            wr_word(1'b1, `CCR_CODE, d);
            paddr = d[16:8];
            q.delete();
            @(posedge clk);
            #1 push = 1'b1;
            @(posedge clk);
            #1 push = 1'b0;
            @(posedge clk);
            #1;
            chk(q.size() == (mw[28] ? 0 : 1), "push count");
            if (!mw[28]) chk(q[0] === paddr, "push index");
        end
        $display("line push test done");
        for (int k = 0; k < 8; k++) begin
            wr_word(1'b1, `CCR_CODE, {k[2], 3'b000, k[1], 27'h0000000});
            tv = k[0];
            @(posedge clk);
            #1 fill = 1'b1;
            @(posedge clk);
            #1 fill = 1'b0;
            chk(fwe === (k[2] & (~k[1] | ~k[0])), "fill permit");
        end
        $display("fill test done");
        wr_word(1'b1, `CCR_CODE, 32'h8800_0401);
        nrst = 1'b0;
        repeat (2) @(posedge clk);
        #1 nrst = 1'b1;
        mw = 32'h0000_0000;
        check_word();
        $display("mid-run reset test done");
        complete_run();
    end
endmodule

`default_nettype wire

// ---- verification/ccr_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module ccr_core_model (
    // Clock
    input wire logic i_clk,
    // Control register move
    output logic o_wr,
    output logic o_supv,
    output logic [11:0] o_code,
    output logic [31:0] o_data
);
    initial begin
        o_wr = 1'b0;
        o_supv = 1'b0;
        o_code = 12'h000;
        o_data = 32'h0000_0000;
    end

    // One write, held across the edge that takes it
    task automatic put(input logic s, input logic [11:0] c,
                       input logic [31:0] d);
        @(posedge i_clk);
        #1;
        o_wr = 1'b1;
        o_supv = s;
        o_code = c;
        o_data = d & 32'h99ff_ffff;
        @(posedge i_clk);
        #1;
        o_wr = 1'b0;
        o_data = ~o_data;
        o_code = ~o_code;
    endtask
endmodule

`default_nettype wire
